// ---- hw/igei_pkg.sv ----
`default_nettype none
package igei_pkg;
    // Command byte values select the register
    localparam logic [7:0] CMD_INPUT    = 8'h00;
    localparam logic [7:0] CMD_OUTPUT   = 8'h01;
    localparam logic [7:0] CMD_POLARITY = 8'h02;
    localparam logic [7:0] CMD_CONFIG   = 8'h03;

    // Values after reset: all pins inputs, outputs high, no inversion
    localparam logic [7:0] RST_CONFIG   = 8'hFF;
    localparam logic [7:0] RST_OUTPUT   = 8'hFF;
    localparam logic [7:0] RST_POLARITY = 8'h00;

    // Bit counter marks within one nine-bit frame
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;

    // Cycles after reset before the synced pins make a valid reference
    localparam int REF_SETTLE = 3;

    // Timing
    localparam int CLK_MHZ   = 50;
    localparam int T_IV_NS   = 4000;
    localparam int T_IR_NS   = 4000;
    localparam int IV_CYCLES = T_IV_NS * CLK_MHZ / 1000;
    localparam int IR_CYCLES = T_IR_NS * CLK_MHZ / 1000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_RDATA,
        ST_WAIT
    } igei_state_t;
endpackage : igei_pkg
`default_nettype wire

// ---- hw/igei_top.sv ----
// Operation
// - Four 8-bit registers: direction, input, output, polarity; one bit per pin.
// - Every pin is an input after power-on and after any reset.
// - Controller sets each pin's direction by writing its direction bit.
// - Set polarity bit reports inverted pin level in input register.
// - Every register can be read back by the controller.
// - Reset pin low restores defaults and bus state machine like power-on.
// - Input edge asserts interrupt low within 4 us.
// - Interrupt stays asserted while any input differs from its stored state.
// - Interrupt drops when input returns or the port is read.
// - Read clears interrupt at acknowledge clock rise, within 4 us.
// - Change during that acknowledge pulse may be lost or very short.
// - After clearing, every later input change signals again.
// - Traffic for other targets leaves interrupt logic alone.
// - Output-mode pins never cause an interrupt.
// - Output-to-input switch may raise a false interrupt; not suppressed.
// - Output mode drives pin high or low from output register bit.
// - Input mode turns both drivers off; pin floats.
// - Address select pin chooses one of two bus addresses.
// - Interrupt is open-drain: pulled low when asserted, else released.
// - Command zero selects the input port register for reading.
`default_nettype none
module igei_top
    import igei_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = 7'h20  // Arbitrary bus address base
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe_out,
    input  wire logic       addr_sel_in,
    input  wire logic [7:0] port_pins_in,
    output var  logic [7:0] port_pins_out,
    output var  logic [7:0] port_pins_oe_out,
    output var  logic       irq_n_out,
    output var  logic       irq_oe_out
);
    localparam int IV_MAX = IV_CYCLES;
    localparam int IR_MAX = IR_CYCLES;

    logic        rst_meta;
    logic        rst_n;
    logic        scl_meta;
    logic        scl_s;
    logic        scl_d;
    logic        sda_meta;
    logic        sda_s;
    logic        sda_d;
    logic        addr_meta;
    logic        addr_s;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_s;
    logic        tog_meta;
    logic        tog_s;
    logic        tog_d;
    logic        link_bit;
    logic        link_tog;
    igei_state_t state;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  tx;
    logic        rw;
    logic [7:0]  cmd;
    logic [7:0]  dir;
    logic [7:0]  outr;
    logic [7:0]  pol;
    logic [7:0]  ref_pins;
    logic [REF_SETTLE-1:0] ref_init;
    logic        low_level;

    // Register read mux, shared by every read load
    function automatic logic [7:0] reg_read(input logic [7:0] sel,
                                            input logic [7:0] in_v,
                                            input logic [7:0] out_v,
                                            input logic [7:0] pol_v,
                                            input logic [7:0] dir_v);
        case (sel)
            CMD_INPUT:    reg_read = in_v;
            CMD_OUTPUT:   reg_read = out_v;
            CMD_POLARITY: reg_read = pol_v;
            CMD_CONFIG:   reg_read = dir_v;
            default:      reg_read = 8'h00;
        endcase
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Link domain: take SDA on each SCL rise, flag it by a toggle.
    // The bit stays put until the next rise, far longer than the sync.
    always_ff @(posedge scl_in or negedge rst_n) begin
        if (!rst_n) begin
            link_bit <= 1'b0;
            link_tog <= 1'b0;
        end else begin
            link_bit <= sda_in;
            link_tog <= ~link_tog;
        end
    end

    // Pin and bus level synchronisers
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta  <= 1'b1;
            scl_s     <= 1'b1;
            scl_d     <= 1'b1;
            sda_meta  <= 1'b1;
            sda_s     <= 1'b1;
            sda_d     <= 1'b1;
            addr_meta <= 1'b0;
            addr_s    <= 1'b0;
            pin_meta  <= 8'h00;
            pin_s     <= 8'h00;
            tog_meta  <= 1'b0;
            tog_s     <= 1'b0;
            tog_d     <= 1'b0;
        end else begin
            scl_meta  <= scl_in;
            scl_s     <= scl_meta;
            scl_d     <= scl_s;
            sda_meta  <= sda_in;
            sda_s     <= sda_meta;
            sda_d     <= sda_s;
            addr_meta <= addr_sel_in;
            addr_s    <= addr_meta;
            pin_meta  <= port_pins_in;
            pin_s     <= pin_meta;
            tog_meta  <= link_tog;
            tog_s     <= tog_meta;
            tog_d     <= tog_s;
        end
    end

    // Bus events and decodes
    wire       start_ev = scl_s & sda_d & ~sda_s;
    wire       stop_ev  = scl_s & ~sda_d & sda_s;
    wire       fall_ev  = scl_d & ~scl_s;
    wire       rise_ev  = tog_s ^ tog_d;
    wire [6:0] my_addr  = {ADDR_BASE[6:1], addr_s};
    wire       addr_ok  = (shreg[7:1] == my_addr);
    wire       ack_fall = fall_ev & (bitcnt == ACK_SLOT);
    wire       end_fall = fall_ev & (bitcnt == ACK_DONE);
    wire       ack_rise = rise_ev & (bitcnt == ACK_SLOT);
    wire [7:0] in_reg   = pin_s ^ pol;
    wire [7:0] rd_data  = reg_read(cmd, in_reg, outr, pol, dir);
    wire       load_tx  = end_fall & ((state == ST_RDATA) |
                                      ((state == ST_ADDR) & rw));
    wire       wr_ev    = ack_fall & (state == ST_WDATA);
    wire       nack_ev  = ack_rise & (state == ST_RDATA) & link_bit;
    // Only our own input-register read clears, so foreign traffic cannot
    wire       rd_clr   = ack_rise & (state == ST_RDATA) &
                          (cmd == CMD_INPUT);
    // Output bits masked, all bits until the reference settles after reset
    wire       ref_ok   = ref_init[REF_SETTLE-1];
    wire [7:0] mismatch = {8{ref_ok}} & dir & (pin_s^ref_pins);

    // Byte framing, acknowledge and transmit state machine
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            tx         <= 8'h00;
            rw         <= 1'b0;
            cmd        <= CMD_INPUT;
            sda_oe_out <= 1'b0;
        end else if (start_ev) begin
            state      <= ST_ADDR;
            bitcnt     <= 4'h0;
            sda_oe_out <= 1'b0;
        end else if (stop_ev) begin
            state      <= ST_IDLE;
            sda_oe_out <= 1'b0;
        end else if (rise_ev) begin
            if (bitcnt == ACK_SLOT) begin
                bitcnt <= ACK_DONE;
            end else begin
                bitcnt <= 4'(bitcnt + 4'h1);
                shreg  <= {shreg[6:0], link_bit};
            end
            if (nack_ev) begin
                state <= ST_WAIT;
            end
        end else if (fall_ev) begin
            case (state)
                ST_ADDR: begin
                    if (ack_fall) begin
                        if (addr_ok) begin
                            sda_oe_out <= 1'b1;
                            rw         <= shreg[0];
                        end else begin
                            state <= ST_WAIT;
                        end
                    end else if (end_fall) begin
                        bitcnt <= 4'h0;
                        state  <= rw ? ST_RDATA : ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (ack_fall) begin
                        sda_oe_out <= 1'b1;
                        cmd        <= shreg;
                    end else if (end_fall) begin
                        bitcnt <= 4'h0;
                        state  <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (ack_fall) begin
                        sda_oe_out <= 1'b1;
                    end else if (end_fall) begin
                        bitcnt <= 4'h0;
                    end
                end
                ST_RDATA: begin
                    if (ack_fall) begin
                        sda_oe_out <= 1'b0; // Controller owns the ack bit
                    end else if (end_fall) begin
                        bitcnt <= 4'h0;
                    end else begin
                        tx         <= {tx[6:0], 1'b0};
                        sda_oe_out <= ~tx[6];
                    end
                end
                default: begin
                    sda_oe_out <= 1'b0;
                end
            endcase
            // Read data leaves MSB first; a zero bit pulls SDA low
            if (load_tx) begin
                tx         <= rd_data;
                sda_oe_out <= ~rd_data[7];
            end else if (end_fall) begin
                sda_oe_out <= 1'b0;
            end
        end
    end

    // Register writes on the data byte's acknowledge
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            dir  <= RST_CONFIG;
            outr <= RST_OUTPUT;
            pol  <= RST_POLARITY;
        end else if (wr_ev) begin
            case (cmd)
                CMD_OUTPUT:   outr <= shreg;
                CMD_POLARITY: pol  <= shreg;
                CMD_CONFIG:   dir  <= shreg;
                default:      outr <= outr;
            endcase
        end
    end

    // Reference levels: track pins until the sync settles, then each input-register read.
    // A pin moving in the same cycle as the read is absorbed, not flagged.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_pins <= 8'h00;
            ref_init <= {REF_SETTLE{1'b0}};
        end else begin
            ref_init <= {ref_init[REF_SETTLE-2:0], 1'b1};
            if (!ref_ok || rd_clr) begin
                ref_pins <= pin_s;
            end
        end
    end

    // Pin drivers and open-drain interrupt, all from flops
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            port_pins_out    <= RST_OUTPUT;
            port_pins_oe_out <= 8'h00;
            irq_oe_out       <= 1'b0;
            low_level        <= 1'b0;
        end else begin
            port_pins_out    <= outr;
            port_pins_oe_out <= ~dir;
            irq_oe_out       <= |mismatch;
            low_level        <= 1'b0;
        end
    end

    // Both open-drain pins only ever pull low
    assign sda_out   = low_level;
    assign irq_n_out = low_level;

    sequence s_read_ack;
        rd_clr;
    endsequence
    sequence s_dir_write;
        wr_ev && (cmd == CMD_CONFIG);
    endsequence

    property p_reset_inputs;
        @(posedge ref_clk_in)
        $rose(rst_n) |-> (dir == RST_CONFIG) && (port_pins_oe_out == 8'h00);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins not inputs after reset");

    property p_irq_valid;
        @(posedge ref_clk_in) disable iff (!rst_n)
        $rose(|mismatch) |-> ##[1:IV_MAX] irq_oe_out;
    endproperty
    a_irq_valid: assert property (p_irq_valid)
        else $error("interrupt late after input edge");

    property p_irq_hold;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (|mismatch) |=> irq_oe_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped while input differs");

    property p_irq_release;
        @(posedge ref_clk_in) disable iff (!rst_n)
        !(|mismatch) |=> !irq_oe_out;
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("interrupt held with no difference");

    property p_out_no_irq;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (dir == 8'h00) |=> !irq_oe_out;
    endproperty
    a_out_no_irq: assert property (p_out_no_irq)
        else $error("output pins raised interrupt");

    property p_read_clear;
        @(posedge ref_clk_in) disable iff (!rst_n)
        s_read_ack ##1 (pin_s == $past(pin_s)) |-> ##[1:IR_MAX] !irq_oe_out;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("port read did not clear interrupt");

    property p_foreign;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (state == ST_ADDR) && ack_fall && !addr_ok && !start_ev && !stop_ev
        |=> (state == ST_WAIT) && !sda_oe_out;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign address not ignored");

    property p_addr_ack;
        @(posedge ref_clk_in) disable iff (!rst_n)
        (state == ST_ADDR) && ack_fall && addr_ok && !start_ev && !stop_ev
        |=> sda_oe_out;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");

    property p_dir_apply;
        @(posedge ref_clk_in) disable iff (!rst_n)
        s_dir_write and (!start_ev && !stop_ev)
        |-> ##2 (port_pins_oe_out == ~$past(shreg, 2));
    endproperty
    a_dir_apply: assert property (p_dir_apply)
        else $error("direction write not applied");
endmodule : igei_top
`default_nettype wire

// ---- sim/igei_host.sv ----
`default_nettype none
// Bus controller model; SCL stands high between frames
module igei_host #(
    parameter int HALF_NS = 400  // Slow enough for the 2FF sync delay
) (
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_low_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle: clock high, data released
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    // Start or repeated start: SDA falls while SCL high
    task automatic bus_start();
        sda_low_out = 1'b0;
        #(HALF_NS) scl_out = 1'b1;
        #(HALF_NS) sda_low_out = 1'b1;
        #(HALF_NS) scl_out = 1'b0;
        #(HALF_NS / 4);
    endtask

    // Stop: SDA rises while SCL high
    task automatic bus_stop();
        sda_low_out = 1'b1;
        #(HALF_NS) scl_out = 1'b1;
        #(HALF_NS) sda_low_out = 1'b0;
        #(HALF_NS);
    endtask

    // Data moves only well after SCL fall, never near it
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = ~b;
        #(HALF_NS) scl_out = 1'b1;
        r = sda_in;
        #(HALF_NS) scl_out = 1'b0;
        #(HALF_NS / 4);
    endtask

    // MSB first, ninth clock carries the acknowledge
    task automatic byte_io(input logic [7:0] d, input logic ack_b,
                           output logic [7:0] q, output logic ack);
        q = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_b, ack);
    endtask

    // Address with write bit, command, data, stop
    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic [2:0] k;
        bus_start();
        byte_io({a, 1'b0}, 1'b1, q, k[0]);
        byte_io(c, 1'b1, q, k[1]);
        byte_io(d, 1'b1, q, k[2]);
        bus_stop();
        ok = (k === 3'b000);
    endtask

    // Command write, repeated start, one byte, nack, stop
    task automatic rd(input logic [6:0] a, input logic [7:0] c,
                      output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic [3:0] k;
        bus_start();
        byte_io({a, 1'b0}, 1'b1, q, k[0]);
        byte_io(c, 1'b1, q, k[1]);
        bus_start();
        byte_io({a, 1'b1}, 1'b1, q, k[2]);
        byte_io(8'hFF, 1'b1, d, k[3]);
        bus_stop();
        ok = (k[2:0] === 3'b000);
    endtask
endmodule // igei_host
`default_nettype wire

// ---- sim/i2c_gpio_expander_irq_tb.sv ----
`default_nettype none
module i2c_gpio_expander_irq_tb import igei_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] BASE = 7'h20;  // Arbitrary bus address
    logic       ref_clk;
    logic       rst_n;
    logic       addr_sel;
    logic [7:0] ext_pins;
    logic       scl;
    logic       host_low;
    logic       sda_out;
    logic       sda_oe;
    logic       irq_n;
    logic       irq_oe;
    logic [7:0] pins_out;
    logic [7:0] pins_oe;
    logic [6:0] dev_a;
    logic [7:0] rdat;
    logic       ok;
    int         err_total;
    int         total_checks;
    wire logic       sda_w;
    wire logic [7:0] pins_w;

    // Wired levels: SDA pulled up, pins follow their driver
    assign sda_w  = ~(host_low | (sda_oe & ~sda_out));
    assign pins_w = (pins_oe & pins_out) | (~pins_oe & ext_pins);

    igei_top #(.ADDR_BASE(BASE)) u_igei_top (
        .ref_clk_in       (ref_clk),
        .rst_n_in         (rst_n),
        .scl_in           (scl),
        .sda_in           (sda_w),
        .sda_out          (sda_out),
        .sda_oe_out       (sda_oe),
        .addr_sel_in      (addr_sel),
        .port_pins_in     (pins_w),
        .port_pins_out    (pins_out),
        .port_pins_oe_out (pins_oe),
        .irq_n_out        (irq_n),
        .irq_oe_out       (irq_oe)
    );

    igei_host #(.HALF_NS(400)) u_igei_host (
        .sda_in      (sda_w),
        .scl_out     (scl),
        .sda_low_out (host_low)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        #2 rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic set_pins(input logic [7:0] v);
        @(posedge ref_clk);
        #2 ext_pins = v;
    endtask

    // Bounded wait; 250 cycles covers the 4 us valid window
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq_oe !== exp && n < 250) begin
            @(posedge ref_clk);
            n++;
        end
        chk({7'h00, irq_oe}, {7'h00, exp}, "irq level");
        if (n >= 250) close_out();
    endtask

    task automatic hold_irq(input logic exp);
        repeat (250) @(posedge ref_clk);
        chk({7'h00, irq_oe}, {7'h00, exp}, "irq held");
    endtask

    task automatic wreg(input logic [7:0] c, input logic [7:0] d);
        u_igei_host.wr(dev_a, c, d, ok);
        chk({7'h00, ok}, 8'h01, "write ack");
    endtask

    task automatic rreg(input logic [7:0] c, input logic [7:0] exp);
        u_igei_host.rd(dev_a, c, rdat, ok);
        chk({7'h00, ok}, 8'h01, "read ack");
        chk(rdat, exp, "read data");
    endtask

    task automatic t_defaults();
        chk(pins_oe, 8'h00, "pins after reset");
        chk({7'h00, irq_oe}, 8'h00, "irq after reset");
        chk({7'h00, irq_n}, 8'h00, "irq drive value");
        rreg(CMD_CONFIG, 8'hFF);
        rreg(CMD_OUTPUT, RST_OUTPUT);
        rreg(CMD_POLARITY, RST_POLARITY);
    endtask

    // Low nibble outputs, high nibble inputs
    task automatic t_regs();
        wreg(CMD_CONFIG, 8'hF0);
        wreg(CMD_OUTPUT, 8'hA5);
        wreg(CMD_POLARITY, 8'h0F);
        chk(pins_oe, 8'h0F, "drive enables");
        chk(pins_oe & pins_out, 8'h05, "driven levels");
        rreg(CMD_CONFIG, 8'hF0);
        rreg(CMD_OUTPUT, 8'hA5);
        rreg(CMD_POLARITY, 8'h0F);
        rreg(CMD_INPUT, 8'h3A);
        hold_irq(1'b0);
    endtask

    task automatic t_irq();
        set_pins(8'hBC);
        wait_irq(1'b1);
        hold_irq(1'b1);
        set_pins(8'h3C);
        wait_irq(1'b0);
        set_pins(8'hBC);
        wait_irq(1'b1);
        rreg(CMD_INPUT, 8'hBA);
        wait_irq(1'b0);
        set_pins(8'h3C);
        wait_irq(1'b1);
        rreg(CMD_INPUT, 8'h3A);
        wait_irq(1'b0);
        set_pins(8'h33);
        hold_irq(1'b0);
        wreg(CMD_OUTPUT, 8'h5A);
        hold_irq(1'b0);
    endtask

    // Select pin moves the device to the odd address
    task automatic t_addr();
        @(posedge ref_clk);
        #2 addr_sel = 1'b1;
        repeat (5) @(posedge ref_clk);
        u_igei_host.wr(BASE, CMD_OUTPUT, 8'h00, ok);
        chk({7'h00, ok}, 8'h00, "old address refused");
        dev_a = {BASE[6:1], 1'b1};
        rreg(CMD_OUTPUT, 8'h5A);
        set_pins(8'h73);
        wait_irq(1'b1);
        u_igei_host.rd(BASE, CMD_INPUT, rdat, ok);
        chk({7'h00, ok}, 8'h00, "other target");
        hold_irq(1'b1);
        set_pins(8'h33);
        wait_irq(1'b0);
    endtask

    // Stored low nibble 5 disagrees with pins 3
    task automatic t_false();
        wreg(CMD_CONFIG, 8'hFF);
        chk(pins_oe, 8'h00, "all released");
        wait_irq(1'b1);
        rreg(CMD_INPUT, 8'h3C);
        wait_irq(1'b0);
    endtask

    task automatic t_midreset();
        wreg(CMD_POLARITY, 8'hFF);
        wreg(CMD_CONFIG, 8'h00);
        chk(pins_oe, 8'hFF, "all driven");
        do_reset();
        chk(pins_oe, 8'h00, "pins after reset");
        chk(pins_out, RST_OUTPUT, "output after reset");
        chk({7'h00, irq_oe}, 8'h00, "irq after reset");
        rreg(CMD_POLARITY, RST_POLARITY);
        rreg(CMD_CONFIG, 8'hFF);
    endtask

    initial begin
        rst_n        = 1'b1;
        addr_sel     = 1'b0;
        ext_pins     = 8'h3C;
        err_total    = 0;
        total_checks = 0;
        dev_a        = {BASE[6:1], 1'b0};
        do_reset();
        t_defaults();
        t_regs();
        t_irq();
        t_addr();
        t_false();
        t_midreset();
        close_out();
    end
endmodule // i2c_gpio_expander_irq_tb
`default_nettype wire
